// ==== hdl/led_pwm_pkg.sv ====
package led_pwm_pkg;

  // clock and time base
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned STEP_NS          = 2500;
  localparam int unsigned STEP_CYC         = (STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLINK_UNIT_US    = 41667;
  localparam int unsigned BLINK_TICK_STEPS = (BLINK_UNIT_US * 1000 / 256) / STEP_NS;
  localparam int unsigned BLINK_TICK_CYC   = BLINK_TICK_STEPS * STEP_CYC;

  // counter geometry
  localparam int unsigned PRE_W      = 8;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned GRP_W      = 5;
  localparam int unsigned BTICK_W    = 7;
  localparam int unsigned N_CHANNELS = 4;

  localparam logic [PRE_W-1:0]   PRE_LAST    = PRE_W'(STEP_CYC - 1);
  localparam logic [BTICK_W-1:0] BTICK_LAST  = BTICK_W'(BLINK_TICK_STEPS - 1);
  localparam logic [5:0]         DIM_WRAP    = 6'h3F;
  localparam logic [7:0]         FAST_BLINK_MAX = 8'h03;

  // reset values
  localparam logic [PRE_W-1:0]   PRE_RST   = 8'h00;
  localparam logic [CNT_W-1:0]   CNT_RST   = 8'h00;
  localparam logic [GRP_W-1:0]   GRP_RST   = 5'h00;
  localparam logic [BTICK_W-1:0] BTICK_RST = 7'h00;
  localparam logic [3:0]         DRV_RST   = 4'h0;
  localparam logic [7:0]         BLINK_RST = 8'h00;
  localparam logic [3:0]         OE_N_RST  = 4'hF;

  // channel state selector codes
  localparam logic [1:0] SEL_OFF   = 2'h0;
  localparam logic [1:0] SEL_ON    = 2'h1;
  localparam logic [1:0] SEL_INDIV = 2'h2;
  localparam logic [1:0] SEL_GROUP = 2'h3;

  typedef struct packed {
    logic output_polarity_flip;
    logic drive_structure_select;
  } second_mode_t;

  typedef struct packed {
    logic       dim_or_blink_select;
    logic [7:0] group_duty_value;
    logic [7:0] group_period_value;
  } group_ctrl_t;

endpackage

// ==== hdl/drive_stage_map.sv ====
module drive_stage_map (
  input  wire logic [1:0] channel_state_field,
  input  wire logic       output_polarity_flip,
  input  wire logic       drive_structure_select,
  input  wire logic       ind_pwm,
  input  wire logic       group_on,
  output logic            upper_on,
  output logic            lower_on
);

  logic gated;
  logic drive;

  always_comb begin
    gated = ind_pwm;
    if (channel_state_field == led_pwm_pkg::SEL_GROUP && !drive_structure_select) begin
      gated = ind_pwm & group_on;                      // see RQ5, see RQ6
    end
    drive = (channel_state_field[1] ? gated : channel_state_field[0]) ^ output_polarity_flip;  // see RQ1, see RQ2, see RQ4
    lower_on = drive;                                  // see RQ3
    // upper is at most the complement of lower, so both transistors can never conduct together
    upper_on = drive_structure_select & ~drive;        // see RQ3, see RQ6
  end

endmodule

// ==== hdl/led_output_pwm.sv ====
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RQ1 - selector 00: off/off in open-drain, upper on totem-pole, lower on if inverted
// RQ2 - selector 01: lower on; inverted gives off (open-drain) or upper on (totem-pole)
// RQ3 - selector 10: lower follows individual PWM, upper complementary only in totem-pole
// RQ4 - selector 10 inverted: outputs use inverted individual PWM, upper off in open-drain
// RQ5 - selector 11 open-drain: lower driven by individual AND group PWM, upper off
// RQ6 - selector 11: inverted gated PWM in open-drain, individual PWM only in totem-pole
// RQ7 - individual PWM runs at 1.5625 kHz with 8-bit duty per channel
// RQ8 - one group signal, dim or blink, shared by all four outputs
// RQ9 - dimming group signal is 190 Hz with 4-bit duty
// RQ10 - blink period programmable 8-bit, from 24 Hz down to about 10.7 s
// RQ11 - blink duty 6-bit for 24..6 Hz, 8-bit from 6 Hz down
// RQ12 - one PWM step lasts 2.5 us; duty N gives N steps high
// RQ13 - group dimming step with duty one lasts 320 us
// RQ14 - group duty one passes exactly two individual PWM pulses per group period
// RQ15 - selector 10 ignores group settings; 256 steps at 1.5625 kHz
// RQ16 - selector 11 dimming: 16-step group at 190 Hz, individual 64 steps at 6.25 kHz
// RQ17 - fast blink: 64-step group duty, 256-step period, individual 256 steps
// RQ18 - slow blink: 256-step group duty and period, individual 256 steps
// RQ19 - polarity flip and drive structure come from the second mode register
// RQ20 - with the oscillator stopped no output switches, dims or blinks
// RQ21 - each output has its own 2-bit field, decoded every oscillator cycle
// RQ22 - all PWM and group timing derives from one free-running counter chain
module led_output_pwm (
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire logic                            ce,
  input  wire logic [7:0]                      output_state_select,
  input  wire logic [3:0][7:0]                 channel_duty_value,
  input  wire led_pwm_pkg::second_mode_t       second_mode_register,
  input  wire led_pwm_pkg::group_ctrl_t        group_ctrl,
  output logic [3:0]                           upper_on,
  output logic [3:0]                           lower_on,
  output logic [3:0]                           led_output_pin_o,
  output logic [3:0]                           led_output_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic ind_pwm_level(input logic [1:0] sel, input logic dim,
                                         input logic [7:0] cnt, input logic [7:0] duty);
    logic lvl;
    lvl = cnt < duty;
    if (sel == led_pwm_pkg::SEL_GROUP && !dim) begin
      lvl = cnt[5:0] < duty[7:2];                      // see RQ16
    end
    return lvl;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // time base: one prescaler feeds every counter below

  logic [led_pwm_pkg::PRE_W-1:0]   pre_r,   pre_nxt;
  logic [led_pwm_pkg::CNT_W-1:0]   ind_cnt_r, ind_cnt_nxt;
  logic [led_pwm_pkg::GRP_W-1:0]   grp_cnt_r, grp_cnt_nxt;
  logic [led_pwm_pkg::BTICK_W-1:0] btick_r, btick_nxt;
  logic [7:0]                      bsub_r,  bsub_nxt;
  logic [7:0]                      bphase_r, bphase_nxt;
  logic                            step_tick;
  logic                            blink_tick;

  always_comb begin
    pre_nxt     = pre_r;
    ind_cnt_nxt = ind_cnt_r;
    grp_cnt_nxt = grp_cnt_r;
    btick_nxt   = btick_r;
    bsub_nxt    = bsub_r;
    bphase_nxt  = bphase_r;
    step_tick   = pre_r == led_pwm_pkg::PRE_LAST;      // see RQ12
    blink_tick  = step_tick && btick_r == led_pwm_pkg::BTICK_LAST;
    if (ce) begin
      pre_nxt = step_tick ? led_pwm_pkg::PRE_RST : pre_r + 8'h01;
      if (step_tick) begin
        ind_cnt_nxt = ind_cnt_r + 8'h01;               // see RQ7, see RQ22
        // group step = two 64-step periods, so 16 steps span 5.12 ms
        if (ind_cnt_r[5:0] == led_pwm_pkg::DIM_WRAP) begin
          grp_cnt_nxt = grp_cnt_r + 5'h01;             // see RQ9, see RQ13
        end
        btick_nxt = blink_tick ? led_pwm_pkg::BTICK_RST : btick_r + 7'h01;
      end
      if (blink_tick) begin
        // each phase step lasts (period value + 1) blink ticks
        if (bsub_r >= group_ctrl.group_period_value) begin
          bsub_nxt   = 8'h00;
          bphase_nxt = bphase_r + 8'h01;               // see RQ10
        end else begin
          bsub_nxt = bsub_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_r     <= led_pwm_pkg::PRE_RST;
      ind_cnt_r <= led_pwm_pkg::CNT_RST;
      grp_cnt_r <= led_pwm_pkg::GRP_RST;
      btick_r   <= led_pwm_pkg::BTICK_RST;
      bsub_r    <= led_pwm_pkg::BLINK_RST;
      bphase_r  <= led_pwm_pkg::BLINK_RST;
    end else begin
      pre_r     <= pre_nxt;
      ind_cnt_r <= ind_cnt_nxt;
      grp_cnt_r <= grp_cnt_nxt;
      btick_r   <= btick_nxt;
      bsub_r    <= bsub_nxt;
      bphase_r  <= bphase_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared group signal

  logic dim_on;
  logic blink_on;
  logic blink_fast;
  logic group_on;

  always_comb begin
    dim_on     = grp_cnt_r[4:1] < group_ctrl.group_duty_value[7:4];          // see RQ9
    blink_fast = group_ctrl.group_period_value <= led_pwm_pkg::FAST_BLINK_MAX;
    // coarse duty at fast rates keeps each blink edge on a 4-step boundary
    blink_on   = blink_fast ? (bphase_r[7:2] < group_ctrl.group_duty_value[7:2])
                            : (bphase_r < group_ctrl.group_duty_value);     // see RQ11, see RQ17, see RQ18
    group_on   = group_ctrl.dim_or_blink_select ? blink_on : dim_on;        // see RQ8
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel output stage

  logic [3:0] ind_pwm;
  logic [3:0] upper_map;
  logic [3:0] lower_map;
  logic [3:0] upper_r, upper_nxt;
  logic [3:0] lower_r, lower_nxt;

  for (genvar ch = 0; ch < led_pwm_pkg::N_CHANNELS; ch++) begin : g_ch
    always_comb begin
      ind_pwm[ch] = ind_pwm_level(output_state_select[2*ch +: 2], group_ctrl.dim_or_blink_select,
                                  ind_cnt_r, channel_duty_value[ch]);       // see RQ15
    end
    drive_stage_map u_map (
      .channel_state_field    (output_state_select[2*ch +: 2]),             // see RQ21
      .output_polarity_flip   (second_mode_register.output_polarity_flip),  // see RQ19
      .drive_structure_select (second_mode_register.drive_structure_select),
      .ind_pwm                (ind_pwm[ch]),
      .group_on               (group_on),
      .upper_on               (upper_map[ch]),
      .lower_on               (lower_map[ch])
    );
  end

  always_comb begin
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    if (ce) begin                                      // see RQ20
      upper_nxt = upper_map;
      lower_nxt = lower_map;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      upper_r <= led_pwm_pkg::DRV_RST;
      lower_r <= led_pwm_pkg::DRV_RST;
    end else begin
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
    end
  end

  // pin view; registered alongside the transistor flags so all outputs are flops
  logic [3:0] pin_o_r;
  logic [3:0] pin_oe_n_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_o_r    <= led_pwm_pkg::DRV_RST;
      pin_oe_n_r <= led_pwm_pkg::OE_N_RST;
    end else begin
      pin_o_r    <= upper_nxt;
      pin_oe_n_r <= ~(upper_nxt | lower_nxt);
    end
  end

  assign upper_on            = upper_r;
  assign lower_on            = lower_r;
  assign led_output_pin_o    = pin_o_r;
  assign led_output_pin_oe_n = pin_oe_n_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [1:0] sel0;
  logic       inv;
  logic       tp;
  logic [8:0] since_step_r;

  assign sel0 = output_state_select[1:0];
  assign inv  = second_mode_register.output_polarity_flip;
  assign tp   = second_mode_register.drive_structure_select;

  always_ff @(posedge clk) begin
    if (!nrst || (ce && step_tick)) begin
      since_step_r <= 9'h000;
    end else if (ce) begin
      since_step_r <= since_step_r + 9'h001;
    end
  end

  chk_off_open_drain: assert property (                                     // see RQ1
    (ce && sel0 == led_pwm_pkg::SEL_OFF && !inv && !tp) |=> (!upper_on[0] && !lower_on[0]))
    else $error("off selector in open-drain left a transistor on");

  chk_off_inverted: assert property (                                       // see RQ1
    (ce && sel0 == led_pwm_pkg::SEL_OFF && inv) |=> (!upper_on[0] && lower_on[0]))
    else $error("inverted off selector did not sink the pin");

  chk_on_states: assert property (                                          // see RQ2
    (ce && sel0 == led_pwm_pkg::SEL_ON) |=>
      (lower_on[0] == !$past(inv)) && (upper_on[0] == ($past(inv) && $past(tp))))
    else $error("on selector drive does not match polarity and structure");

  chk_indiv_follow: assert property (                                       // see RQ3
    (ce && sel0 == led_pwm_pkg::SEL_INDIV && !inv) |=>
      (lower_on[0] == $past(ind_pwm[0])) && (upper_on[0] == ($past(tp) && !$past(ind_pwm[0]))))
    else $error("individual PWM not followed on channel 0");

  chk_indiv_invert: assert property (                                       // see RQ4
    (ce && sel0 == led_pwm_pkg::SEL_INDIV && inv && !tp) |=>
      (lower_on[0] == !$past(ind_pwm[0])) && !upper_on[0])
    else $error("inverted individual PWM wrong on channel 0");

  chk_group_gate: assert property (                                         // see RQ5
    (ce && sel0 == led_pwm_pkg::SEL_GROUP && !inv && !tp) |=>
      (lower_on[0] == ($past(ind_pwm[0]) && $past(group_on))) && !upper_on[0])
    else $error("group gating wrong in open-drain");

  chk_group_totem: assert property (                                        // see RQ6
    (ce && sel0 == led_pwm_pkg::SEL_GROUP && tp) |=>
      (lower_on[0] == ($past(ind_pwm[0]) ^ $past(inv))) && (upper_on[0] == !lower_on[0]))
    else $error("totem-pole group mode must ignore the group signal");

  chk_step_length: assert property (                                        // see RQ12
    (ce && step_tick) |-> (since_step_r == 9'(led_pwm_pkg::STEP_CYC - 1)))
    else $error("PWM step is not 250 cycles");

  chk_indiv_duty: assert property (                                         // see RQ7
    (sel0 == led_pwm_pkg::SEL_INDIV) |-> (ind_pwm[0] == (ind_cnt_r < channel_duty_value[0])))
    else $error("individual duty compare wrong");

  chk_dim_two_pulses: assert property (                                     // see RQ14
    (!group_ctrl.dim_or_blink_select && group_ctrl.group_duty_value[7:4] == 4'h1) |->
      (group_on == (grp_cnt_r[4:1] == 4'h0)))
    else $error("group duty one must open exactly two individual periods");

  chk_freeze: assert property (                                             // see RQ20
    (!ce) |=> ($stable(upper_on) && $stable(lower_on) && $stable(ind_cnt_r) && $stable(bphase_r)))
    else $error("state moved while the oscillator was stopped");

  // blink ticks are counted in enabled cycles, so a frozen oscillator does not stretch them
  logic [14:0] since_btick_r;

  always_ff @(posedge clk) begin
    if (!nrst || (ce && blink_tick)) begin
      since_btick_r <= 15'h0000;
    end else if (ce) begin
      since_btick_r <= since_btick_r + 15'h0001;
    end
  end

  chk_blink_tick_len: assert property (                                     // see RQ10
    (ce && blink_tick) |-> (since_btick_r == 15'(led_pwm_pkg::BLINK_TICK_CYC - 1)))
    else $error("blink tick spacing is not 65 PWM steps");

  chk_group_step: assert property (                                         // see RQ13
    ce |=> (grp_cnt_r == $past(grp_cnt_r) +
      (($past(step_tick) && $past(ind_cnt_r[5:0]) == led_pwm_pkg::DIM_WRAP) ? 5'h01 : 5'h00)))
    else $error("group dimming counter did not advance once per 64 steps");

  chk_group_inverted: assert property (                                     // see RQ6
    (ce && sel0 == led_pwm_pkg::SEL_GROUP && inv && !tp) |=>
      (lower_on[0] == !($past(ind_pwm[0]) && $past(group_on))) && !upper_on[0])
    else $error("inverted group gating wrong in open-drain");

  chk_fast_blink_duty: assert property (                                    // see RQ11
    (ce && sel0 == led_pwm_pkg::SEL_GROUP && !tp && group_ctrl.dim_or_blink_select &&
     group_ctrl.group_period_value <= led_pwm_pkg::FAST_BLINK_MAX && group_ctrl.group_duty_value[7:2] == 6'h00) |=>
      (lower_on[0] == $past(inv)))
    else $error("fast blink did not drop the low duty bits");

  cov_dim_mode: cover property (
    ce && sel0 == led_pwm_pkg::SEL_GROUP && !group_ctrl.dim_or_blink_select && $rose(group_on));

  cov_blink_phase: cover property (ce && blink_tick && group_ctrl.dim_or_blink_select);

  cov_indiv_pulse: cover property (ce && sel0 == led_pwm_pkg::SEL_INDIV && $fell(lower_on[0]));

  cov_group_inverted: cover property (ce && sel0 == led_pwm_pkg::SEL_GROUP && inv && !tp && lower_on[0]);

  cov_totem_source: cover property (ce && tp && $rose(upper_on[0]));

endmodule

// ==== tb/led_load_model.sv ====
module led_load_model (
  input  wire logic [3:0] upper_on,
  input  wire logic [3:0] lower_on,
  input  wire logic [3:0] led_output_pin_o,
  input  wire logic [3:0] led_output_pin_oe_n,
  output logic [3:0]      led_level,
  output logic [3:0]      clash
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin is pulled up through the led or its resistor, never left floating
  assign led_level = led_output_pin_oe_n | led_output_pin_o;
  // both transistors on shorts the supply, the load flags it
  assign clash = upper_on & lower_on;
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                             clk = 1'b0;
  logic                             nrst = 1'b0;
  logic                             ce = 1'b0;
  logic [7:0]                       output_state_select = 8'h00;
  logic [3:0][7:0]                  channel_duty_value = '0;
  led_pwm_pkg::second_mode_t        second_mode_register = '0;
  led_pwm_pkg::group_ctrl_t         group_ctrl = '0;
  logic [3:0]                       upper_on, lower_on, pin_o, pin_oe_n, led_level, clash, prev, v;
  logic                             en_q = 1'b0;
  int                               err_total = 0;
  int                               n_tests = 0;
  int                               hi[4];
  int                               rise[4];
  int                               en_n;
  int                               exp_hi;
  bit                               bad;

  always #5 clk = ~clk;
  always @(posedge clk) en_q <= ce & nrst;

  led_output_pwm u_dut (.clk(clk), .nrst(nrst), .ce(ce), .output_state_select(output_state_select),
    .channel_duty_value(channel_duty_value), .second_mode_register(second_mode_register),
    .group_ctrl(group_ctrl), .upper_on(upper_on), .lower_on(lower_on), .led_output_pin_o(pin_o),
    .led_output_pin_oe_n(pin_oe_n));
  led_load_model u_load (.upper_on(upper_on), .lower_on(lower_on), .led_output_pin_o(pin_o),
    .led_output_pin_oe_n(pin_oe_n), .led_level(led_level), .clash(clash));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      err_total++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic restart(input logic [7:0] s, input logic [31:0] d, input logic [1:0] m, input logic [16:0] g);
    @(posedge clk);
    nrst <= 1'b0;
    output_state_select <= s;
    channel_duty_value <= d;
    second_mode_register <= m;
    group_ctrl <= g;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    ce <= 1'b1;
    prev = 4'h0;
  endtask

  // counts lower-transistor on-time over enabled cycles; ce drops for 100 cycles to check the freeze
  task automatic run_win(input int n);
    hi = '{default: 0};
    rise = '{default: 0};
    en_n = 0;
    bad = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ce <= (i < 100 || i >= 200);
      @(negedge clk);
      if (en_q) begin
        en_n++;
        for (int c = 0; c < 4; c++) begin
          hi[c] += (lower_on[c] === 1'b1);
          rise[c] += (lower_on[c] === 1'b1 && prev[c] === 1'b0);
        end
        prev = lower_on;
        if (second_mode_register.drive_structure_select && upper_on !== ~lower_on) bad = 1'b1;
      end else if (lower_on !== prev) begin
        bad = 1'b1;
      end
      if (clash !== 4'h0) bad = 1'b1;
    end
    check(!bad, "drive not complementary, clashing or moving while stopped");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    test_stopped();
    test_static();
    test_indiv();
    test_dim();
    test_blink();
    test_done();
  end

  // oscillator stopped after reset: nothing may drive
  task automatic test_stopped;
    output_state_select <= 8'h55;
    repeat (20) @(posedge clk);
    @(negedge clk);
    check(lower_on === 4'h0 && pin_oe_n === 4'hF, "outputs moved with oscillator stopped");
  endtask

  // static states, alternating channels so a swapped field shows
  task automatic test_static;
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        @(posedge clk);
        ce <= 1'b1;
        output_state_select <= s ? 8'h11 : 8'h44;
        second_mode_register <= 2'(m);
        repeat (3) @(posedge clk);
        @(negedge clk);
        v = (s ? 4'h5 : 4'hA) ^ {4{m[1]}};
        // a pin that neither transistor holds must read high through the load
        bad = !(lower_on === v && upper_on === ({4{m[0]}} & ~v));
        bad |= !(pin_oe_n === ~(v | upper_on) && led_level === ~v);
        check(!bad, "static drive decode");
      end
    end
  endtask

  // individual pwm in all four polarity and structure settings, group settings must be ignored
  task automatic test_indiv;
    for (int m = 0; m < 4; m++) begin
      restart(8'hAA, 32'h00010205, 2'(m), 17'h10000);
      run_win(2000);
      for (int c = 0; c < 4; c++) begin
        exp_hi = channel_duty_value[c] * led_pwm_pkg::STEP_CYC;
        check(hi[c] == (m[1] ? en_n - exp_hi : exp_hi), "individual pulse width");
      end
    end
  endtask

  // group dimming with duty one: two 64-step pulses per group period
  task automatic test_dim;
    restart(8'h2F, 32'h00020408, 2'b00, 17'h01000);
    run_win(48000);
    check(rise[0] == 2 && hi[0] == 1000, "dim pulses with group duty one");
    check(hi[1] == 500, "six-bit individual duty in dimming");
    check(hi[2] == 500 && rise[2] == 1 && hi[3] == 0, "mixed selectors under dimming");
  endtask

  task automatic test_blink;
    // fast rate drops duty 3 to no on-time; inverted open-drain then sinks all the time
    restart(8'hFF, 32'h02020202, 2'b10, 17'h10300);
    run_win(2000);
    for (int c = 0; c < 4; c++) begin
      check(hi[c] == en_n, "fast blink duty");
    end
    // slow rate keeps the low bits: phase 0 lies inside duty 1
    restart(8'hFF, 32'h02020202, 2'b00, 17'h10104);
    run_win(2000);
    for (int c = 0; c < 4; c++) begin
      check(hi[c] == 500, "slow blink duty");
    end
    // totem-pole ignores the group signal even at duty zero
    restart(8'hFF, 32'h02020202, 2'b01, 17'h10000);
    run_win(2000);
    for (int c = 0; c < 4; c++) begin
      check(hi[c] == 500, "totem-pole group bypass");
    end
  endtask

  initial begin
    #900us;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
